// ### common/ras_pkg.sv
// Constants and types shared by the alarm and indicator sequencer
// ============================================================================
// How it works
// [RULE1] Degraded array: one second on, one off
// [RULE2] Failed array: three seconds on, one off
// [RULE3] Hot spare commissioned: one on, three off
// [RULE4] Cadence repeats until cleared, silenced or disabled
// [RULE5] Silence is dropped by every reboot
// [RULE6] Disable survives reboots until explicitly cleared
// [RULE7] Disabled alarm never sounds until re-enabled
// [RULE8] Rebuild holds the alarm steadily on
// [RULE9] Rebuild completion plays one distinct tone once
// [RULE10] Green heartbeat follows processor activity
// [RULE11] Red indicator lit on board error
// [RULE12] Dirty cache output while unwritten data held
// [RULE13] Drive fault output when any drive faults
// [RULE14] Drive activity output follows drive activity
// [RULE15] Factory defaults input restores board settings
// [RULE16] Memory reads: fix single-bit, flag multi-bit
// [RULE17] Most severe cadence wins: failed, degraded, spare
package ras_pkg;

    // ========================================================================
    // Timing
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned SEC_MS      = 1000;
    localparam int unsigned SEC_CYC     = CLK_HZ / 1000 * SEC_MS;
    localparam logic [2:0]  DEGR_ON_S   = 3'h1;
    localparam logic [2:0]  DEGR_OFF_S  = 3'h1;
    localparam logic [2:0]  FAIL_ON_S   = 3'h3;
    localparam logic [2:0]  FAIL_OFF_S  = 3'h1;
    localparam logic [2:0]  SPARE_ON_S  = 3'h1;
    localparam logic [2:0]  SPARE_OFF_S = 3'h3;
    localparam logic [2:0]  DONE_S      = 3'h1;

    // ========================================================================
    // Register map and fields
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_COND  = 8'h04;
    localparam logic [7:0] OFS_STAT  = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0C;
    localparam logic [7:0] OFS_ALARM = 8'h10;
    localparam int unsigned CTRL_SIL  = 0;
    localparam int unsigned CTRL_DIS  = 1;
    localparam int unsigned CTRL_DONE = 2;
    localparam int unsigned ST_W      = 4;
    localparam logic        DIS_RST   = 1'b0;
    localparam logic        SIL_RST   = 1'b0;
    localparam logic [3:0]  MASK_RST  = 4'h0;
    localparam logic [5:0]  COND_RST  = 6'h00;

    // ========================================================================
    // Memory check code
    localparam int unsigned ECC_DW = 64;
    localparam int unsigned ECC_CW = 72;

    typedef enum logic [5:0] {
        MD_QUIET   = 6'h01,
        MD_SPARE   = 6'h02,
        MD_DEGR    = 6'h04,
        MD_FAIL    = 6'h08,
        MD_DONE    = 6'h10,
        MD_REBUILD = 6'h20
    } ras_mode_t;

    typedef struct packed {
        logic dirty;
        logic board_err;
        logic rebuild;
        logic spare;
        logic failed;
        logic degraded;
    } ras_cond_t;

    typedef struct packed {
        logic [ECC_DW-1:0] data;
        logic              ce;
        logic              ue;
    } ras_ecc_t;

    typedef struct packed {
        logic raise;
        logic done;
        logic ue;
        logic ce;
    } ras_stat_t;

endpackage : ras_pkg

// ### hw/ras_alarm_seq.sv
// Alarm cadence sequencer, indicators, memory check and APB registers
`timescale 1ns/1ps
`default_nettype none

module ras_alarm_seq #(
    parameter int unsigned TICK_CYC   = ras_pkg::SEC_CYC,
    parameter int unsigned NUM_DRIVES = 8
) (
    // Clock and resets
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    input  wire logic                         por_n,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Board sources
    input  wire logic                         cpu_activity,
    input  wire logic [NUM_DRIVES-1:0]        drive_fault,
    input  wire logic [NUM_DRIVES-1:0]        drive_busy,
    input  wire logic                         factory_defaults_header,
    input  wire logic                         ecc_rd_valid,
    input  wire logic [ras_pkg::ECC_CW-1:0]   ecc_rd_code,
    // Buzzer and indicators
    output logic                              alarm_out,
    output logic                              alarm_tone_alt,
    output logic                              irq,
    output logic                              heartbeat_indicator,
    output logic                              board_error_indicator,
    output logic                              dirty_cache_header,
    output logic                              drive_fault_header,
    output logic                              drive_activity_header,
    // Checked read data
    output ras_pkg::ras_ecc_t                 ecc_rd_out,
    output logic                              ecc_out_valid
);

    // ========================================================================
    // Helpers
    function automatic logic [2:0] on_len(input ras_pkg::ras_mode_t m);
        case (m)
            ras_pkg::MD_DEGR:  on_len = ras_pkg::DEGR_ON_S;
            ras_pkg::MD_FAIL:  on_len = ras_pkg::FAIL_ON_S;
            ras_pkg::MD_SPARE: on_len = ras_pkg::SPARE_ON_S;
            default:           on_len = 3'h0;
        endcase
    endfunction : on_len

    function automatic logic [2:0] off_len(input ras_pkg::ras_mode_t m);
        case (m)
            ras_pkg::MD_DEGR:  off_len = ras_pkg::DEGR_OFF_S;
            ras_pkg::MD_FAIL:  off_len = ras_pkg::FAIL_OFF_S;
            ras_pkg::MD_SPARE: off_len = ras_pkg::SPARE_OFF_S;
            default:           off_len = 3'h0;
        endcase
    endfunction : off_len

    // Extended Hamming: bit 0 overall parity, powers of two are checks
    function automatic ras_pkg::ras_ecc_t ecc_fix(
        input logic [ras_pkg::ECC_CW-1:0] cw
    );
        logic [6:0]                 syn;
        logic                       par;
        logic [ras_pkg::ECC_CW-1:0] c;
        logic [6:0]                 k;
        ras_pkg::ras_ecc_t          r;
        syn = 7'h00;
        par = ^cw;
        c   = cw;
        k   = 7'h00;
        r   = '0;
        for (int i = 1; i < ras_pkg::ECC_CW; i++) begin
            if (cw[i]) begin
                syn = syn ^ 7'(i);
            end
        end
        if (par) begin
            if (syn < 7'(ras_pkg::ECC_CW)) begin
                c[syn] = ~c[syn];                      // [RULE16]
                r.ce   = 1'b1;
            end else begin
                r.ue = 1'b1;
            end
        end else if (syn != 7'h00) begin
            r.ue = 1'b1;                               // [RULE16]
        end
        for (int i = 1; i < ras_pkg::ECC_CW; i++) begin
            if ((i & (i - 1)) != 0) begin
                r.data[k[5:0]] = c[i];
                k = k + 7'h01;
            end
        end
        return r;
    endfunction : ecc_fix

    // ========================================================================
    // APB decode
    logic access;
    logic setup;
    logic mapped;
    logic wr_ctrl;
    logic rd_stat;

    assign access  = psel & penable;
    assign setup   = psel & ~penable;
    assign mapped  = (paddr == ras_pkg::OFS_CTRL) | (paddr == ras_pkg::OFS_COND)
                   | (paddr == ras_pkg::OFS_STAT) | (paddr == ras_pkg::OFS_MASK)
                   | (paddr == ras_pkg::OFS_ALARM);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_ctrl = access & pwrite & (paddr == ras_pkg::OFS_CTRL);
    assign rd_stat = access & ~pwrite & (paddr == ras_pkg::OFS_STAT);

    logic                  fact_q;
    logic                  dis_q;
    logic                  sil_q;
    ras_pkg::ras_cond_t    cond_q;
    ras_pkg::ras_cond_t    cond_prev_q;
    logic [3:0]            mask_q;
    ras_pkg::ras_stat_t    stat_q;
    ras_pkg::ras_stat_t    stat_set;
    logic [31:0]           prdata_q;
    ras_pkg::ras_mode_t    mode_q;
    ras_pkg::ras_mode_t    mode_d;
    logic                  phase_on_q;
    logic [2:0]            sec_cnt_q;
    logic [31:0]           tick_cnt_q;
    logic                  sec_tick;
    logic                  done_act_q;
    logic [2:0]            done_cnt_q;
    logic                  done_end;
    logic                  alarm_q;
    logic                  tone_alt_q;
    ras_pkg::ras_ecc_t     ecc_q;
    logic                  ecc_vld_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fact_q <= 1'b0;
        end else begin
            fact_q <= factory_defaults_header;
        end
    end

    // ========================================================================
    // Settings
    // Disable survives a reboot; only a power-on reset, the factory defaults input or a control write clears it
    always_ff @(posedge ref_clk or negedge por_n) begin
        if (!por_n) begin
            dis_q <= ras_pkg::DIS_RST;
        end else if (fact_q) begin
            dis_q <= ras_pkg::DIS_RST;                 // [RULE15]
        end else if (wr_ctrl) begin
            dis_q <= pwdata[ras_pkg::CTRL_DIS];        // [RULE6]
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sil_q <= ras_pkg::SIL_RST;                 // [RULE5]
        end else if (fact_q) begin
            sil_q <= ras_pkg::SIL_RST;                 // [RULE15]
        end else if (wr_ctrl) begin
            sil_q <= pwdata[ras_pkg::CTRL_SIL];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_q      <= ras_pkg::COND_RST;
            cond_prev_q <= ras_pkg::COND_RST;
        end else begin
            cond_prev_q <= cond_q;
            if (access && pwrite && paddr == ras_pkg::OFS_COND) begin
                cond_q <= pwdata[5:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= ras_pkg::MASK_RST;
        end else if (fact_q) begin
            mask_q <= ras_pkg::MASK_RST;               // [RULE15]
        end else if (access && pwrite && paddr == ras_pkg::OFS_MASK) begin
            mask_q <= pwdata[3:0];
        end
    end

    // ========================================================================
    // Read data and event status
    // Read data is latched in setup so the clear only drops bits seen
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            case (paddr)
                ras_pkg::OFS_CTRL:  prdata_q <= {29'h0, 1'b0, dis_q, sil_q};
                ras_pkg::OFS_COND:  prdata_q <= {26'h0, cond_q};
                ras_pkg::OFS_STAT:  prdata_q <= {28'h0, stat_q};
                ras_pkg::OFS_MASK:  prdata_q <= {28'h0, mask_q};
                ras_pkg::OFS_ALARM: prdata_q <= {22'h0, mode_q, phase_on_q,
                                                 tone_alt_q, dis_q, alarm_q};
                default:            prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_q;

    assign stat_set.ce    = ecc_vld_q & ecc_q.ce;
    assign stat_set.ue    = ecc_vld_q & ecc_q.ue;
    assign stat_set.done  = done_end;
    assign stat_set.raise = |({cond_q.failed, cond_q.degraded, cond_q.spare}
                          & ~{cond_prev_q.failed, cond_prev_q.degraded,
                              cond_prev_q.spare});

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~(rd_stat ? prdata_q[3:0] : 4'h0)) | stat_set;
        end
    end

    assign irq = |(stat_q & mask_q);

    // ========================================================================
    // Mode selection
    always_comb begin
        if (cond_q.rebuild) begin
            mode_d = ras_pkg::MD_REBUILD;              // [RULE8]
        end else if (done_act_q && !done_end) begin
            mode_d = ras_pkg::MD_DONE;                 // [RULE9]
        end else if (cond_q.failed) begin
            mode_d = ras_pkg::MD_FAIL;                 // [RULE17]
        end else if (cond_q.degraded) begin
            mode_d = ras_pkg::MD_DEGR;                 // [RULE17]
        end else if (cond_q.spare) begin
            mode_d = ras_pkg::MD_SPARE;                // [RULE17]
        end else begin
            mode_d = ras_pkg::MD_QUIET;                // [RULE4]
        end
    end

    // Second divider restarts on a mode change so the first beat is whole
    assign sec_tick = (tick_cnt_q == TICK_CYC - 1);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= 32'h0000_0000;
        end else if (mode_d != mode_q || sec_tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // ========================================================================
    // Cadence
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q     <= ras_pkg::MD_QUIET;
            phase_on_q <= 1'b1;
            sec_cnt_q  <= 3'h0;
        end else if (mode_d != mode_q) begin
            mode_q     <= mode_d;
            phase_on_q <= 1'b1;
            sec_cnt_q  <= 3'h0;
        end else if (sec_tick && on_len(mode_q) != 3'h0) begin
            if (phase_on_q && sec_cnt_q + 3'h1 == on_len(mode_q)) begin
                phase_on_q <= 1'b0;                    // [RULE1] [RULE2] [RULE3]
                sec_cnt_q  <= 3'h0;
            end else if (!phase_on_q
                         && sec_cnt_q + 3'h1 == off_len(mode_q)) begin
                phase_on_q <= 1'b1;                    // [RULE4]
                sec_cnt_q  <= 3'h0;
            end else begin
                sec_cnt_q  <= sec_cnt_q + 3'h1;
            end
        end
    end

    // Completion tone only counts down while it is actually playing
    assign done_end = done_act_q && mode_q == ras_pkg::MD_DONE && sec_tick
                      && done_cnt_q == ras_pkg::DONE_S - 3'h1;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_act_q <= 1'b0;
            done_cnt_q <= 3'h0;
        end else if (wr_ctrl && pwdata[ras_pkg::CTRL_DONE]) begin
            done_act_q <= 1'b1;
            done_cnt_q <= 3'h0;
        end else if (done_end) begin
            done_act_q <= 1'b0;                        // [RULE9]
        end else if (done_act_q && mode_q == ras_pkg::MD_DONE && sec_tick) begin
            done_cnt_q <= done_cnt_q + 3'h1;
        end
    end

    // Silence and disable mute every tone, including the completion tone
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q    <= 1'b0;
            tone_alt_q <= 1'b0;
        end else begin
            alarm_q    <= !dis_q && !sil_q && phase_on_q      // [RULE7] [RULE4]
                          && mode_q != ras_pkg::MD_QUIET;
            tone_alt_q <= mode_q == ras_pkg::MD_DONE;         // [RULE9]
        end
    end

    assign alarm_out      = alarm_q;
    assign alarm_tone_alt = tone_alt_q;

    // ========================================================================
    // Indicators
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            heartbeat_indicator   <= 1'b0;
            board_error_indicator <= 1'b0;
            dirty_cache_header    <= 1'b0;
            drive_fault_header    <= 1'b0;
            drive_activity_header <= 1'b0;
        end else begin
            heartbeat_indicator   <= cpu_activity;            // [RULE10]
            board_error_indicator <= cond_q.board_err;        // [RULE11]
            dirty_cache_header    <= cond_q.dirty;            // [RULE12]
            drive_fault_header    <= |drive_fault;            // [RULE13]
            drive_activity_header <= |drive_busy;             // [RULE14]
        end
    end

    // ========================================================================
    // Memory read check, one cycle of latency
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ecc_q     <= '0;
            ecc_vld_q <= 1'b0;
        end else begin
            ecc_vld_q <= ecc_rd_valid;
            if (ecc_rd_valid) begin
                ecc_q <= ecc_fix(ecc_rd_code);                // [RULE16]
            end
        end
    end

    assign ecc_rd_out    = ecc_q;
    assign ecc_out_valid = ecc_vld_q;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_disable_mutes_alarm: assert property (dis_q |=> !alarm_q) // [RULE7]
        else $error("alarm sounded while disabled");

    a_quiet_no_alarm: assert property ( // [RULE4]
        mode_q == ras_pkg::MD_QUIET |=> !alarm_q)
        else $error("alarm sounded with no condition");

    a_rebuild_steady_on: assert property ( // [RULE8]
        (mode_q == ras_pkg::MD_REBUILD && mode_d == mode_q && !dis_q && !sil_q)
        [*2] |=> alarm_q)
        else $error("rebuild tone not steady");

    a_fail_on_three: assert property ( // [RULE2]
        (mode_q == ras_pkg::MD_FAIL && mode_d == mode_q && phase_on_q
         && sec_tick) |=> (phase_on_q == ($past(sec_cnt_q) != 3'h2)))
        else $error("failed cadence on time wrong");

    a_degr_off_one: assert property ( // [RULE1]
        (mode_q == ras_pkg::MD_DEGR && mode_d == mode_q && !phase_on_q
         && sec_tick) |=> phase_on_q)
        else $error("degraded cadence off time wrong");

    a_spare_off_three: assert property ( // [RULE3]
        (mode_q == ras_pkg::MD_SPARE && mode_d == mode_q && !phase_on_q
         && sec_tick && sec_cnt_q < 3'h2) |=> !phase_on_q)
        else $error("spare cadence off too short");

    a_severity_order: assert property ( // [RULE17]
        (cond_q.failed && !cond_q.rebuild && !done_act_q) |=>
        mode_q == ras_pkg::MD_FAIL)
        else $error("failed array not given priority");

    a_done_once: assert property ( // [RULE9]
        (done_end || !done_act_q)
        && !(wr_ctrl && pwdata[ras_pkg::CTRL_DONE]) |=> !done_act_q)
        else $error("completion tone repeated");

    a_fault_led: assert property ((|drive_fault) |=> drive_fault_header) // [RULE13]
        else $error("drive fault not shown");

    a_ecc_flags: assert property (ecc_rd_valid |=> ecc_out_valid // [RULE16]
        && !(ecc_rd_out.ce && ecc_rd_out.ue))
        else $error("read check flags inconsistent");

    c_fail_cadence: cover property (mode_q == ras_pkg::MD_FAIL && $fell(alarm_q));
    c_spare_cadence: cover property (mode_q == ras_pkg::MD_SPARE && $rose(alarm_q));
    c_done_tone: cover property (done_end);
    c_ecc_fix: cover property (ecc_vld_q && ecc_q.ce);

endmodule : ras_alarm_seq

`default_nettype wire

// ### verif/ras_buzzer_model.sv
// Buzzer model: measures the last finished on and off runs of the tone
`timescale 1ns/1ps
`default_nettype none

module ras_buzzer_model (
    // Clock and buzzer drive
    input  wire logic   clk,
    input  wire logic   sound,
    // Last finished runs, in cycles
    output int unsigned on_len,
    output int unsigned off_len
);
    int unsigned cnt  = 0;
    logic        last = 1'b0;

    // A buzzer only hears the level, so run lengths are all it keeps
    always @(posedge clk) begin
        if (sound !== last) begin
            if (last)
                on_len <= cnt;
            else
                off_len <= cnt;
            cnt <= 1;
        end else
            cnt <= cnt + 1;
        last <= sound;
    end
endmodule : ras_buzzer_model
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the alarm and indicator sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ============
    // Signals
    localparam int unsigned TK = 20;
    logic        ref_clk = 1'b0;
    logic        arst_n  = 1'b0;
    logic        por_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        cpu_act = 1'b0;
    logic        fdef    = 1'b0;
    logic        evld    = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [7:0]  dflt    = 8'h00;
    logic [7:0]  dbsy    = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [71:0] code    = 72'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, err, alarm, alt, irq, hb, berr;
    logic        dirty, dflh, dact, evo;
    ras_pkg::ras_ecc_t eout;
    int unsigned on_len, off_len;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          k, t, i;
    int          cnd[6]  = '{1, 2, 4, 7, 5, 6};
    int          eon[6]  = '{1, 3, 1, 3, 1, 3};
    int          eoff[6] = '{1, 1, 3, 1, 1, 1};

    always #12.5 ref_clk = ~ref_clk;

    ras_alarm_seq #(.TICK_CYC(TK), .NUM_DRIVES(8)) u_ras_alarm_seq (
        .ref_clk(ref_clk), .arst_n(arst_n), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_activity(cpu_act), .drive_fault(dflt), .drive_busy(dbsy),
        .factory_defaults_header(fdef), .ecc_rd_valid(evld),
        .ecc_rd_code(code), .alarm_out(alarm), .alarm_tone_alt(alt),
        .irq(irq), .heartbeat_indicator(hb), .board_error_indicator(berr),
        .dirty_cache_header(dirty), .drive_fault_header(dflh),
        .drive_activity_header(dact), .ecc_rd_out(eout),
        .ecc_out_valid(evo));
    ras_buzzer_model u_ras_buzzer_model (.clk(ref_clk), .sound(alarm),
        .on_len(on_len), .off_len(off_len));

    // ============
    // Helpers; every driver starts just after a rising edge
    task automatic chk(input logic [65:0] g, input logic [65:0] e,
                       input string m);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk

    task automatic conclude();
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Counts tone and alternate-pitch cycles over a window
    task automatic count(input int skip, input int n);
        k = 0;
        t = 0;
        repeat (skip) @(posedge ref_clk);
        repeat (n) begin
            @(negedge ref_clk);
            k += (alarm === 1'b1);
            t += (alt === 1'b1);
        end
    endtask : count

    task automatic reboot();
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
    endtask : reboot

    // Check bits at powers of two, overall even parity in bit 0
    function automatic logic [71:0] enc(input logic [63:0] v);
        logic [71:0] c;
        int          j;
        c = 72'h0;
        j = 0;
        for (int n = 1; n < 72; n++)
            if ((n & (n - 1)) != 0) begin
                c[n] = v[j];
                j++;
            end
        for (int p = 1; p < 72; p *= 2)
            for (int n = 1; n < 72; n++)
                if ((n & p) != 0 && n != p)
                    c[p] ^= c[n];
        c[0] = ^c;
        return c;
    endfunction : enc

    // Kind 0 clean, 1 one flipped bit, 2 two flipped bits
    task automatic ecc(input int kind);
        logic [71:0] c;
        logic [63:0] v;
        int          b;
        v = {$urandom, $urandom};
        c = enc(v);
        b = $urandom_range(70, 0);
        if (kind > 0)
            c[b] = ~c[b];
        if (kind > 1)
            c[b + 1] = ~c[b + 1];
        @(posedge ref_clk);
        code <= c;
        evld <= 1'b1;
        @(posedge ref_clk);
        evld <= 1'b0;
        @(negedge ref_clk);
        chk(evo, 1, "ecc valid");
        if (kind < 2)
            chk(eout, {v, kind == 1, 1'b0}, "ecc word");
        else
            chk(eout[1:0], 2'b01, "ecc flags");
    endtask : ecc

    // ============
    // Main sequence
    initial begin
        void'($urandom(72139));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        apb(0, ras_pkg::OFS_ALARM, 0);
        chk(rd, 32'h18, "alarm reg reset");
        apb(0, 8'h40, 0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        for (i = 0; i < 6; i++) begin
            apb(1, ras_pkg::OFS_COND, cnd[i]);
            repeat (170) @(posedge ref_clk);
            @(negedge ref_clk);
            chk({on_len, off_len}, {eon[i] * TK, eoff[i] * TK},
                "cadence");
        end
        apb(1, ras_pkg::OFS_COND, 32'h9);
        count(4, 100);
        chk(k, 100, "rebuild steady");
        apb(1, ras_pkg::OFS_COND, 0);
        apb(1, ras_pkg::OFS_CTRL, 32'h4);
        count(0, 150);
        chk({k, t}, {32'd20, 32'd20}, "done tone once");
        apb(1, ras_pkg::OFS_COND, 1);
        apb(1, ras_pkg::OFS_CTRL, 1);
        count(3, 60);
        chk(k, 0, "silenced");
        reboot();
        apb(0, ras_pkg::OFS_CTRL, 0);
        chk(rd, 0, "silence dropped");
        apb(1, ras_pkg::OFS_COND, 1);
        count(3, 60);
        chk(k != 0, 1, "sounds again");
        apb(1, ras_pkg::OFS_COND, 0);
        count(3, 60);
        chk(k, 0, "cause cleared");
        apb(1, ras_pkg::OFS_CTRL, 32'h2);
        reboot();
        apb(0, ras_pkg::OFS_CTRL, 0);
        chk(rd, 32'h2, "disable kept");
        apb(1, ras_pkg::OFS_COND, 2);
        count(3, 90);
        chk(k, 0, "disabled");
        apb(1, ras_pkg::OFS_CTRL, 0);
        count(3, 90);
        chk(k != 0, 1, "re-enabled");
        apb(1, ras_pkg::OFS_CTRL, 32'h2);
        @(posedge ref_clk);
        fdef <= 1'b1;
        repeat (3) @(posedge ref_clk);
        fdef <= 1'b0;
        apb(0, ras_pkg::OFS_CTRL, 0);
        chk(rd, 0, "factory defaults");
        apb(1, ras_pkg::OFS_COND, 32'h30);
        repeat (20) begin
            @(posedge ref_clk);
            cpu_act <= 1'($urandom);
            dflt <= 8'($urandom) & 8'($urandom) & 8'($urandom);
            dbsy <= 8'($urandom) & 8'($urandom);
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk(hb, cpu_act, "heartbeat");
            chk(dflh, |dflt, "drive fault");
            chk(dact, |dbsy, "drive activity");
            chk({berr, dirty}, 2'b11, "board lamps");
        end
        apb(1, ras_pkg::OFS_COND, 0);
        count(2, 1);
        chk({berr, dirty}, 2'b00, "board lamps off");
        apb(0, ras_pkg::OFS_STAT, 0);
        for (i = 0; i < 9; i++)
            ecc(i % 3);
        count(3, 1);
        apb(0, ras_pkg::OFS_STAT, 0);
        chk(rd, 32'h3, "ecc status");
        ecc(1);
        count(3, 1);
        chk(irq, 0, "masked irq");
        apb(1, ras_pkg::OFS_MASK, 32'h1);
        count(2, 1);
        chk(irq, 1, "irq raised");
        apb(0, ras_pkg::OFS_STAT, 0);
        count(2, 1);
        chk({irq, rd}, {1'b0, 32'h1}, "irq cleared");
        conclude();
    end

    // Whole run is near 1850 cycles; this cuts a hang
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
